/* src/bscan_tap.v */
`timescale 1ns/1ps
`include "bscan_defines.vh"
// Function
// - SAMPLE/PRELOAD captures pins into boundary register, allows shifting preload pattern
// - EXTEST drives boundary register onto outputs, captures inputs
// - BYPASS puts one-bit bypass register between TDI and TDO
// - USERCODE shifts out 32-bit user code register
// - IDCODE shifts out identification register
// - HIGHZ selects bypass and tri-states every I/O pin
// - CLAMP selects bypass, holds pins at boundary register values
// - Reconfig instruction pulses internal request, physical request pin untouched
// - I/O-config instruction loads I/O settings, halts configuration in progress
// - Status held low from I/O-config issue until its register updates
// - Bus hold or weak pull-up overrides high-impedance under test instructions
module bscan_tap (
  input wire clk_i,
  input wire sys_rst_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  input wire trst_n_i,
  input wire [`NPIN-1:0] pin_in_i,
  input wire [`NPIN-1:0] core_out_i,
  input wire [`NPIN-1:0] core_oe_i,
  input wire [`NPIN-1:0] keeper_en_i,
  input wire config_request_n_i,
  input wire config_busy_i,
  output reg tdo_o,
  output reg tdo_oe_o,
  output reg [`NPIN-1:0] pin_out_o,
  output reg [`NPIN-1:0] pin_oe_o,
  output reg [`NPIN-1:0] pin_keep_o,
  output reg [`NPIN-1:0] core_in_o,
  output reg reconfig_o,
  output reg config_halt_o,
  output reg config_status_n_o,
  output reg [`IOCFG_W-1:0] io_element_cfg_o
);
  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  // Pins are sampled by clk_i, so a tck edge is seen two cycles late
  wire [3:0] ls;
  wire [`NPIN-1:0] pin_s;
  pin_sync #(.W(4)) u_link (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i({tck_i, tms_i, tdi_i, trst_n_i}),
    .q_o(ls)
  );
  pin_sync #(.W(`NPIN)) u_pins (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(pin_in_i),
    .q_o(pin_s)
  );
  // Request pin enters inverted so the flops' reset value reads as no request
  wire cfg_req_s;
  pin_sync #(.W(1)) u_req (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(~config_request_n_i),
    .q_o(cfg_req_s)
  );
  wire tck_s = ls[3];
  wire tms_s = ls[2];
  wire tdi_s = ls[1];
  wire trst_s_n = ls[0];
  reg tck_d_r;
  wire rise = tck_s & ~tck_d_r;
  wire fall = ~tck_s & tck_d_r;
  // ----------------------------------------
  // TAP state machine
  // ----------------------------------------
  reg [`S_W-1:0] st_r;
  reg [`S_W-1:0] st_nxt;
  always @*
  begin
    case (st_r)
      `S_RESET: st_nxt = tms_s ? `S_RESET : `S_IDLE;
      `S_IDLE: st_nxt = tms_s ? `S_SEL_DR : `S_IDLE;
      `S_SEL_DR: st_nxt = tms_s ? `S_SEL_IR : `S_CAP_DR;
      `S_CAP_DR: st_nxt = tms_s ? `S_EX1_DR : `S_SH_DR;
      `S_SH_DR: st_nxt = tms_s ? `S_EX1_DR : `S_SH_DR;
      `S_EX1_DR: st_nxt = tms_s ? `S_UPD_DR : `S_PAU_DR;
      `S_PAU_DR: st_nxt = tms_s ? `S_EX2_DR : `S_PAU_DR;
      `S_EX2_DR: st_nxt = tms_s ? `S_UPD_DR : `S_SH_DR;
      `S_UPD_DR: st_nxt = tms_s ? `S_SEL_DR : `S_IDLE;
      `S_SEL_IR: st_nxt = tms_s ? `S_RESET : `S_CAP_IR;
      `S_CAP_IR: st_nxt = tms_s ? `S_EX1_IR : `S_SH_IR;
      `S_SH_IR: st_nxt = tms_s ? `S_EX1_IR : `S_SH_IR;
      `S_EX1_IR: st_nxt = tms_s ? `S_UPD_IR : `S_PAU_IR;
      `S_PAU_IR: st_nxt = tms_s ? `S_EX2_IR : `S_PAU_IR;
      `S_EX2_IR: st_nxt = tms_s ? `S_UPD_IR : `S_SH_IR;
      `S_UPD_IR: st_nxt = tms_s ? `S_SEL_DR : `S_IDLE;
      default: st_nxt = `S_RESET;
    endcase
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [`IR_W-1:0] ir_sh_r;
  reg [`IR_W-1:0] ir_r;
  reg bypass_r;
  reg [`ID_W-1:0] dr32_r;
  reg [`UC_W-1:0] usercode_r;
  reg [`BSR_W-1:0] bsr_sh_r;
  reg [`BSR_W-1:0] bsr_r;
  reg [`IOCFG_W-1:0] iocfg_sh_r;
  reg cfgio_hold_r;
  wire [`BSR_W-1:0] bsr_cap = {pin_s, core_out_i, core_oe_i};
  wire in_ext = (ir_r == `IR_EXTEST);
  wire in_clamp = (ir_r == `IR_CLAMP);
  wire in_highz = (ir_r == `IR_HIGHZ);
  wire sel_bsr = (ir_r == `IR_SAMPLE) | in_ext;
  wire sel_id = (ir_r == `IR_IDCODE);
  wire sel_uc = (ir_r == `IR_USERCODE);
  wire sel_io = (ir_r == `IR_CONFIG_IO);
  // Unknown codes fall to bypass, as the standard expects
  wire sel_byp = ~(sel_bsr | sel_id | sel_uc | sel_io);
  wire ir_upd_go = rise & (st_r == `S_UPD_IR);
  wire dr_upd_go = rise & (st_r == `S_UPD_DR);
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      tck_d_r <= 1'b0;
      st_r <= `S_RESET;
      ir_sh_r <= `IR_CAPTURE;
      ir_r <= `IR_IDCODE;
      bypass_r <= 1'b0;
      dr32_r <= {`ID_W{1'b0}};
      usercode_r <= `USERCODE_RST;
      bsr_sh_r <= {`BSR_W{1'b0}};
      bsr_r <= {`BSR_W{1'b0}};
      iocfg_sh_r <= {`IOCFG_W{1'b0}};
      io_element_cfg_o <= {`IOCFG_W{1'b0}};
      cfgio_hold_r <= 1'b0;
      reconfig_o <= 1'b0;
      config_halt_o <= 1'b0;
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else
    begin
      tck_d_r <= tck_s;
      reconfig_o <= 1'b0;
      config_halt_o <= 1'b0;
      if (!trst_s_n)
      begin
        st_r <= `S_RESET;
        ir_r <= `IR_IDCODE;
      end
      else if (rise)
      begin
        st_r <= st_nxt;
        case (st_r)
          `S_RESET: ir_r <= `IR_IDCODE;
          `S_CAP_IR: ir_sh_r <= `IR_CAPTURE;
          `S_SH_IR: ir_sh_r <= {tdi_s, ir_sh_r[`IR_W-1:1]};
          `S_CAP_DR:
          begin
            bypass_r <= 1'b0;
            if (sel_id)
              dr32_r <= `IDCODE_VAL;
            if (sel_uc)
              dr32_r <= usercode_r;
            if (sel_bsr)
              bsr_sh_r <= bsr_cap;
          end
          `S_SH_DR:
          begin
            if (sel_byp)
              bypass_r <= tdi_s;
            if (sel_id | sel_uc)
              dr32_r <= {tdi_s, dr32_r[`ID_W-1:1]};
            if (sel_bsr)
              bsr_sh_r <= {tdi_s, bsr_sh_r[`BSR_W-1:1]};
            if (sel_io)
              iocfg_sh_r <= {tdi_s, iocfg_sh_r[`IOCFG_W-1:1]};
          end
          `S_UPD_DR:
          begin
            if (sel_bsr)
              bsr_r <= bsr_sh_r;
            if (sel_io)
            begin
              io_element_cfg_o <= iocfg_sh_r;
              cfgio_hold_r <= 1'b0;
            end
          end
          `S_UPD_IR:
          begin
            ir_r <= ir_sh_r;
            if (ir_sh_r == `IR_RECONFIG)
              reconfig_o <= 1'b1;
            if (ir_sh_r == `IR_CONFIG_IO)
            begin
              cfgio_hold_r <= 1'b1;
              config_halt_o <= config_busy_i;
            end
          end
          default: ;
        endcase
      end
      else if (fall)
      begin
        // TDO changes on the falling test-clock edge
        tdo_oe_o <= (st_r == `S_SH_DR) | (st_r == `S_SH_IR);
        if (st_r == `S_SH_IR)
          tdo_o <= ir_sh_r[0];
        else if (sel_id | sel_uc)
          tdo_o <= dr32_r[0];
        else if (sel_bsr)
          tdo_o <= bsr_sh_r[0];
        else if (sel_io)
          tdo_o <= iocfg_sh_r[0];
        else
          tdo_o <= bypass_r;
      end
    end
  end
  // ----------------------------------------
  // Pin control
  // ----------------------------------------
  wire [`NPIN-1:0] b_out = bsr_r[2*`NPIN-1:`NPIN];
  wire [`NPIN-1:0] b_oe = bsr_r[`NPIN-1:0];
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pin_out_o <= {`NPIN{1'b0}};
      pin_oe_o <= {`NPIN{1'b0}};
      pin_keep_o <= {`NPIN{1'b0}};
      core_in_o <= {`NPIN{1'b0}};
      config_status_n_o <= 1'b1;
    end
    else
    begin
      core_in_o <= pin_s;
      config_status_n_o <= ~cfgio_hold_r & ~cfg_req_s;
      if (in_ext | in_clamp)
      begin
        pin_out_o <= b_out;
        pin_oe_o <= b_oe;
      end
      else if (in_highz)
      begin
        pin_out_o <= {`NPIN{1'b0}};
        pin_oe_o <= {`NPIN{1'b0}};
      end
      else
      begin
        pin_out_o <= core_out_i;
        pin_oe_o <= core_oe_i;
      end
      // Keeper stays active where a test instruction floats a pin
      if (in_ext | in_clamp)
        pin_keep_o <= keeper_en_i & ~b_oe;
      else if (in_highz)
        pin_keep_o <= keeper_en_i;
      else
        pin_keep_o <= keeper_en_i & ~core_oe_i;
    end
  end
endmodule // bscan_tap

/* src/bscan_defines.vh */
`ifndef BSCAN_DEFINES_VH
`define BSCAN_DEFINES_VH
// ----------------------------------------
// Instruction register
// ----------------------------------------
`define IR_W 10
`define IR_SAMPLE 10'h005
`define IR_EXTEST 10'h00f
`define IR_BYPASS 10'h3ff
`define IR_USERCODE 10'h007
`define IR_IDCODE 10'h006
`define IR_HIGHZ 10'h00b
`define IR_CLAMP 10'h00a
`define IR_RECONFIG 10'h001
`define IR_CONFIG_IO 10'h00d
`define IR_CAPTURE 10'h001
// ----------------------------------------
// Data registers
// ----------------------------------------
`define ID_W 32
`define UC_W 32
`define NPIN 4
`define BSR_W 12
`define IOCFG_W 8
// Arbitrary identification value
`define IDCODE_VAL 32'h1234_5001
`define USERCODE_RST 32'hffff_ffff
// ----------------------------------------
// TAP states
// ----------------------------------------
`define S_W 16
`define S_RESET 16'h0001
`define S_IDLE 16'h0002
`define S_SEL_DR 16'h0004
`define S_CAP_DR 16'h0008
`define S_SH_DR 16'h0010
`define S_EX1_DR 16'h0020
`define S_PAU_DR 16'h0040
`define S_EX2_DR 16'h0080
`define S_UPD_DR 16'h0100
`define S_SEL_IR 16'h0200
`define S_CAP_IR 16'h0400
`define S_SH_IR 16'h0800
`define S_EX1_IR 16'h1000
`define S_PAU_IR 16'h2000
`define S_EX2_IR 16'h4000
`define S_UPD_IR 16'h8000
`endif

/* src/pin_sync.v */
`timescale 1ns/1ps
// ----------------------------------------
// Two-flop synchroniser
// ----------------------------------------
module pin_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_r;
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_r <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // pin_sync

/* verification/bscan_tap_monitor.sv */
`timescale 1ns/1ps
// ----------
// Checker
// ----------
module bscan_tap_monitor (
  input wire clk_i,
  input wire sys_rst_i,
  input wire tck_i,
  input wire config_busy_i,
  input wire tdo_o,
  input wire tdo_oe_o,
  input wire reconfig_o,
  input wire config_halt_o,
  input wire config_status_n_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  AST_RECONFIG_PULSE: assert property (reconfig_o |=> !reconfig_o [*8])
    else $error("reconfig pulse too long");
  AST_HALT_PULSE: assert property (config_halt_o |=> !config_halt_o [*8])
    else $error("halt pulse too long");
  AST_HALT_BUSY: assert property (config_halt_o |-> $past(config_busy_i))
    else $error("halt without busy");
  AST_HALT_STATUS: assert property (config_halt_o |=> !config_status_n_o)
    else $error("status high after halt");
  AST_STATUS_HOLD: assert property ($fell(config_status_n_o) |=> !config_status_n_o [*8])
    else $error("status low too briefly");
  AST_STATUS_RISE: assert property ($rose(config_status_n_o) |-> !$past(config_status_n_o, 8))
    else $error("status rose too early");
  AST_TDO_OE_MIN: assert property ($rose(tdo_oe_o) |=> tdo_oe_o [*3])
    else $error("tdo enable too short");
  AST_TDO_EDGE: assert property ((tdo_oe_o && $past(tdo_oe_o) && $changed(tdo_o)) |-> !$past(tck_i))
    else $error("tdo moved while tck high");
  COV_RECONFIG: cover property (reconfig_o);
  COV_HALT: cover property (config_halt_o);
  COV_STATUS: cover property ($rose(config_status_n_o));
  COV_SHIFT: cover property ($rose(tdo_oe_o));
endmodule // bscan_tap_monitor
bind bscan_tap bscan_tap_monitor u_mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tck_i(tck_i),
  .config_busy_i(config_busy_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .reconfig_o(reconfig_o),
  .config_halt_o(config_halt_o), .config_status_n_o(config_status_n_o));

/* verification/jtag_ctl.sv */
`timescale 1ns/1ps
// ----------
// Scan controller model
// ----------
module jtag_ctl (
  input wire logic clk_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o
);
  logic t;
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b1;
  end
  // 160 ns per bit; tck stands low between frames
  task automatic step(input logic ms, input logic di, output logic dq);
    tms_o = ms;
    tdi_o = di;
    #80;
    dq = tdo_i;
    tck_o = 1'b1;
    // TDI flips while TCK is high so a late sample would show the wrong bit
    #40;
    tdi_o = ~di;
    #40;
    tck_o = 1'b0;
  endtask
  task automatic tap_reset();
    @(posedge clk_i);
    #2;
    trst_n_o = 1'b0;
    #160;
    trst_n_o = 1'b1;
    repeat (5) step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
  endtask
  // Whole codes only, LSB first, then Update and back to Idle
  task automatic shift(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    @(posedge clk_i);
    #2;
    step(1'b1, 1'b0, t);
    if (ir)
      step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
    step(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
  endtask
endmodule // jtag_ctl

/* verification/tb.sv */
`timescale 1ns/1ps
`include "bscan_defines.vh"
module tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [`NPIN-1:0] pin_in = 4'h9;
  logic busy = 1'b0;
  logic req_n = 1'b1;
  wire tck, tms, tdi, trst_n, tdo, tdo_oe, rc, halt, st_n;
  wire [`NPIN-1:0] pin_out, pin_oe, pin_keep, core_in;
  wire [`IOCFG_W-1:0] io_cfg;
  int n_fail = 0;
  int checks = 0;
  int n_rc = 0;
  int n_halt = 0;
  logic [31:0] d;
  bscan_tap uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .pin_in_i(pin_in), .core_out_i(4'h6), .core_oe_i(4'hf), .keeper_en_i(4'h5),
    .config_request_n_i(req_n), .config_busy_i(busy), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pin_out_o(pin_out),
    .pin_oe_o(pin_oe), .pin_keep_o(pin_keep), .core_in_o(core_in), .reconfig_o(rc), .config_halt_o(halt),
    .config_status_n_o(st_n), .io_element_cfg_o(io_cfg));
  jtag_ctl ctl (.clk_i(clk_i), .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));
  always @(posedge clk_i) if (rc) n_rc <= n_rc + 1;
  always @(posedge clk_i) if (halt) n_halt <= n_halt + 1;
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_ident();
    ctl.shift(1'b0, 32, 32'h0, d);
    cmp(d, `IDCODE_VAL);
    cmp(tdo_oe, 1'b0);
    ctl.shift(1'b1, 10, {22'h0, `IR_USERCODE}, d);
    cmp(d[9:0], `IR_CAPTURE);
    ctl.shift(1'b0, 32, 32'h0, d);
    cmp(d, `USERCODE_RST);
  endtask
  task automatic t_bypass();
    logic [9:0] code;
    for (int k = 0; k < 4; k++)
    begin
      code = (k == 0) ? `IR_BYPASS : (k == 1) ? `IR_HIGHZ : (k == 2) ? `IR_CLAMP : 10'h2aa;
      ctl.shift(1'b1, 10, {22'h0, code}, d);
      if (code == `IR_HIGHZ)
        cmp({pin_oe, pin_keep}, 8'h05);
      ctl.shift(1'b0, 8, 32'h5a, d);
      cmp(d[7:0], 8'hb4);
    end
  endtask
  task automatic t_boundary();
    ctl.shift(1'b1, 10, {22'h0, `IR_SAMPLE}, d);
    cmp({pin_out, pin_oe}, 8'h6f);
    ctl.shift(1'b0, 12, 32'hc3, d);
    cmp(d[11:8], 4'h9);
    ctl.shift(1'b1, 10, {22'h0, `IR_EXTEST}, d);
    cmp({pin_out, pin_oe, pin_keep}, 12'hc34);
    pin_in = 4'h3;
    ctl.shift(1'b0, 12, 32'h3a5, d);
    cmp({d[11:8], pin_out, pin_oe}, 12'h3a5);
    ctl.shift(1'b1, 10, {22'h0, `IR_CLAMP}, d);
    cmp({pin_out, pin_oe, pin_keep}, 12'ha50);
    cmp(core_in, 4'h3);
  endtask
  task automatic t_config();
    @(posedge clk_i);
    #2;
    req_n = 1'b0;
    repeat (12) @(posedge clk_i);
    #2;
    cmp(st_n, 1'b0);
    req_n = 1'b1;
    repeat (12) @(posedge clk_i);
    #2;
    cmp(st_n, 1'b1);
    ctl.shift(1'b1, 10, {22'h0, `IR_RECONFIG}, d);
    cmp({n_rc[3:0], st_n}, 5'h03);
    busy = 1'b1;
    ctl.shift(1'b1, 10, {22'h0, `IR_CONFIG_IO}, d);
    cmp({n_halt[3:0], st_n}, 5'h02);
    ctl.shift(1'b0, 8, 32'ha5, d);
    cmp({st_n, io_cfg}, 9'h1a5);
    busy = 1'b0;
    ctl.shift(1'b1, 10, {22'h0, `IR_CONFIG_IO}, d);
    cmp({n_halt[3:0], st_n}, 5'h02);
    ctl.shift(1'b0, 8, 32'h3c, d);
    cmp({st_n, io_cfg}, 9'h13c);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    #2;
    sys_rst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    ctl.tap_reset();
    t_ident();
    t_bypass();
    t_boundary();
    t_config();
    wrap_up();
  end
  // Tests need about 60 us; a hang is cut off well beyond that
  initial
  begin
    #400000;
    n_fail++;
    wrap_up();
  end
endmodule // tb
